//--- verilog/frame_stats_pkg.sv
// constants, types and helpers shared by the frame statistics block
//------------------------------------------------------------------------------
// Overview of operation
// [R1] exposure is a 16-bit cycle count split over high and low byte registers
// [R2] host reads exposure high byte then low byte back to back
// [R3] exposure adapts each frame to keep average and peak pixel in range
// [R4] peak register takes the largest pixel of each frame, 0 to 254
// [R5] lowest register takes the smallest pixel of each frame, 0 to 254
// [R6] all pixels summed in 17 bits; top eight bits refreshed each frame
// [R7] intensity total equals full sum divided by 512
// [R8] intensity total spans 0 up to 241
// [R9] host computes average as total times 512 over 484
// [R10] capture port loads one array pixel per frame while the pixel ready flag is clear
// [R11] any write to capture port restarts readout at pixel 0,0
// [R12] pixel ready flag rises when capture data is valid; host polls it
// [R13] each capture read with the pixel ready flag set advances the readout pointer by itself
// [R14] readout never stops; pointer wraps to first pixel and flags it
// [R15] pixel ready flag reads 1 with capture byte present, else 0
// [R16] first pixel flag reads 1 when capture data is from pixel 0,0
// [R17] index maps column-major to 22x22: quotient column, remainder row
//------------------------------------------------------------------------------
package frame_stats_pkg;

   //---------------------------------------------------------------------------
   // register map
   //---------------------------------------------------------------------------
   localparam int unsigned ADDR_W = 7;
   localparam logic [6:0] ADDR_EXPOSURE_UPPER = 7'h06;
   localparam logic [6:0] ADDR_EXPOSURE_LOWER = 7'h07;
   localparam logic [6:0] ADDR_PEAK_PIXEL = 7'h08;
   localparam logic [6:0] ADDR_INTENSITY_TOTAL = 7'h09;
   localparam logic [6:0] ADDR_LOWEST_PIXEL = 7'h0a;
   localparam logic [6:0] ADDR_CAPTURE_PORT = 7'h0b;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   //---------------------------------------------------------------------------
   // reset values
   //---------------------------------------------------------------------------
   localparam logic [15:0] RST_EXPOSURE = 16'h0064;
   localparam logic [7:0] RST_PEAK_PIXEL = 8'hd0;
   localparam logic [7:0] RST_INTENSITY_TOTAL = 8'h80;
   localparam logic [7:0] RST_LOWEST_PIXEL = 8'h00;
   localparam logic [7:0] RST_CAPTURE = 8'h00;
   localparam logic [7:0] RST_RUN_MIN = 8'hff;

   //---------------------------------------------------------------------------
   // array geometry and statistics widths
   //---------------------------------------------------------------------------
   localparam int unsigned ARRAY_DIM = 22;
   localparam int unsigned PIXEL_COUNT = 484;
   localparam logic [8:0] LAST_INDEX = 9'h1e3;
   localparam logic [7:0] PIXEL_MAX = 8'hfe;
   localparam int unsigned SUM_W = 17;
   localparam int unsigned SUM_SHIFT = 9;
   localparam int unsigned FIFO_DEPTH = 8;

   //---------------------------------------------------------------------------
   // exposure control loop
   //---------------------------------------------------------------------------
   localparam logic [7:0] PEAK_HIGH = 8'hf0;
   localparam logic [7:0] PEAK_LOW = 8'h80;
   localparam logic [7:0] TOTAL_HIGH = 8'ha0;
   localparam logic [7:0] TOTAL_LOW = 8'h40;
   localparam logic [15:0] EXPOSURE_MIN = 16'h0010;
   localparam logic [15:0] EXPOSURE_MAX = 16'hfff0;
   localparam int unsigned EXPOSURE_SHIFT = 3;

   //---------------------------------------------------------------------------
   // types
   //---------------------------------------------------------------------------
   typedef struct packed {
      logic sof;
      logic [7:0] value;
   } pix_beat_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [6:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic [4:0] col;
      logic [4:0] row;
   } coord_t;

   typedef enum logic [1:0] {
      ST_ACCUM = 2'b01,
      ST_PUBLISH = 2'b10
   } stats_fsm_t;

   //---------------------------------------------------------------------------
   // helpers
   //---------------------------------------------------------------------------
   // column-major mapping of a linear pixel index [R17]
   function automatic coord_t pixel_coord(input logic [8:0] idx);
      coord_t c;
      logic [8:0] q;
      logic [8:0] r;
      q = idx / 9'(ARRAY_DIM);
      r = idx % 9'(ARRAY_DIM);
      c.col = q[4:0];
      c.row = r[4:0];
      return c;
   endfunction

endpackage

//--- verilog/pixel_fifo.sv
// parameterised valid/ready fifo for the pixel stream
`timescale 1ns/1ps
module pixel_fifo
   import frame_stats_pkg::*;
#(
   parameter int unsigned WIDTH = 9,
   parameter int unsigned DEPTH = 8
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);

   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // refuse depths the pointer wrap cannot serve
   if (DEPTH < 2 || WIDTH < 1) begin : g_bad_param
      $error("pixel_fifo needs DEPTH >= 2 and WIDTH >= 1");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] wr_ptr;
      logic [PW-1:0] rd_ptr;
      logic has_room;
      logic has_data;
   } fifo_state_t;

   fifo_state_t st;
   fifo_state_t next_st;

   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   // room and data are kept as flops so both ready and valid leave glitch-free
   always_comb begin
      logic push;
      logic pop;
      push = 1'b0;
      pop = 1'b0;
      next_st = st;
      push = in_valid && st.has_room;
      pop = out_ready && st.has_data;
      if (push) begin
         next_st.mem[st.wr_ptr] = in_data;
         next_st.wr_ptr = ptr_inc(st.wr_ptr);
      end
      if (pop) begin
         next_st.rd_ptr = ptr_inc(st.rd_ptr);
      end
      if (push && !pop) begin
         next_st.has_data = 1'b1;
         next_st.has_room = (ptr_inc(st.wr_ptr) != st.rd_ptr);
      end else if (pop && !push) begin
         next_st.has_room = 1'b1;
         next_st.has_data = (ptr_inc(st.rd_ptr) != st.wr_ptr);
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= '{mem: '0, wr_ptr: '0, rd_ptr: '0, has_room: 1'b1, has_data: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign in_ready = st.has_room;
   assign out_valid = st.has_data;
   assign out_data = st.mem[st.rd_ptr];

endmodule

//--- verilog/frame_stats.sv
// per-frame pixel statistics, auto exposure and test pixel capture port
`timescale 1ns/1ps
module frame_stats
   import frame_stats_pkg::*;
#(
   parameter int unsigned BUF_DEPTH = FIFO_DEPTH
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   // pixel stream from the array readout
   input wire pix_beat_t pix_in,
   input wire logic pix_in_valid,
   output logic pix_in_ready,
   // decoded register accesses from the serial port
   input wire reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // status bits for the motion status register
   output logic pixel_ready_flag,
   output logic first_pixel_flag,
   // live exposure and capture position
   output logic [15:0] exposure_value,
   output coord_t capture_coord
);

   //---------------------------------------------------------------------------
   // elaboration checks
   //---------------------------------------------------------------------------
   if (BUF_DEPTH < 2) begin : g_bad_depth
      $error("frame_stats needs BUF_DEPTH >= 2");
   end

   //---------------------------------------------------------------------------
   // state
   //---------------------------------------------------------------------------
   typedef struct packed {
      stats_fsm_t fsm;
      logic [8:0] idx;
      logic [SUM_W-1:0] sum;
      logic [7:0] run_max;
      logic [7:0] run_min;
      logic [7:0] peak;
      logic [7:0] lowest;
      logic [7:0] total;
      logic [15:0] exposure;
      logic [7:0] lower_snap;
      logic snap_ok;
      logic [7:0] capture;
      logic [8:0] ptr;
      logic ready;
      logic first;
      coord_t coord;
      logic [7:0] rdata;
      logic rvalid;
   } stats_state_t;

   stats_state_t st;
   stats_state_t next_st;

   //---------------------------------------------------------------------------
   // input buffering
   //---------------------------------------------------------------------------
   // the buffer absorbs the stream while the publish cycle stalls the drain
   pix_beat_t fifo_beat;
   logic fifo_valid;
   logic fifo_ready;
   logic fifo_in_ready;

   pixel_fifo #(
      .WIDTH($bits(pix_beat_t)),
      .DEPTH(BUF_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .in_data(pix_in),
      .in_valid(pix_in_valid),
      .in_ready(fifo_in_ready),
      .out_data(fifo_beat),
      .out_valid(fifo_valid),
      .out_ready(fifo_ready)
   );

   assign fifo_ready = (st.fsm == ST_ACCUM);

   //---------------------------------------------------------------------------
   // exposure control
   //---------------------------------------------------------------------------
   // proportional step of one eighth, never less than one cycle, clamped
   function automatic logic [15:0] exposure_adjust(
      input logic [15:0] expo,
      input logic [7:0] peak,
      input logic [7:0] total
   );
      logic [15:0] step;
      logic [15:0] res;
      step = expo >> EXPOSURE_SHIFT;
      res = expo;
      if (step == 16'h0000) begin
         step = 16'h0001;
      end
      if (peak > PEAK_HIGH || total > TOTAL_HIGH) begin
         res = (expo > EXPOSURE_MIN + step) ? expo - step : EXPOSURE_MIN;
      end else if (peak < PEAK_LOW && total < TOTAL_LOW) begin
         res = (expo < EXPOSURE_MAX - step) ? expo + step : EXPOSURE_MAX;
      end
      return res;
   endfunction

   //---------------------------------------------------------------------------
   // next state
   //---------------------------------------------------------------------------
   always_comb begin
      logic take;
      logic [8:0] idx;
      logic [7:0] clamped;
      logic [8:0] ptr_next;
      take = 1'b0;
      idx = 9'h000;
      clamped = 8'h00;
      ptr_next = 9'h000;
      next_st = st;
      next_st.rvalid = 1'b0;

      take = (st.fsm == ST_ACCUM) && fifo_valid;
      // a start-of-frame beat resynchronises the index
      idx = fifo_beat.sof ? 9'h000 : st.idx;
      // peak and lowest never report the saturated code
      clamped = (fifo_beat.value > PIXEL_MAX) ? PIXEL_MAX : fifo_beat.value; // [R4] [R5]

      unique case (st.fsm)
         ST_ACCUM: begin
            if (take) begin
               if (idx == 9'h000) begin
                  next_st.sum = SUM_W'(fifo_beat.value); // [R6]
                  next_st.run_max = clamped;
                  next_st.run_min = clamped;
               end else begin
                  next_st.sum = st.sum + SUM_W'(fifo_beat.value); // [R6]
                  next_st.run_max = (clamped > st.run_max) ? clamped : st.run_max; // [R4]
                  next_st.run_min = (clamped < st.run_min) ? clamped : st.run_min; // [R5]
               end
               // one pixel per frame lands in the capture port, only while the ready flag is clear
               if (!st.ready && idx == st.ptr) begin
                  next_st.capture = fifo_beat.value; // [R10]
                  next_st.ready = 1'b1; // [R12] [R15]
               end
               if (idx == LAST_INDEX) begin
                  next_st.idx = 9'h000;
                  next_st.fsm = ST_PUBLISH;
               end else begin
                  next_st.idx = idx + 9'h001;
               end
            end
         end
         ST_PUBLISH: begin
            // one stalled cycle publishes the finished frame
            next_st.peak = st.run_max; // [R4]
            next_st.lowest = st.run_min; // [R5]
            // 17-bit sum over 512; 484 pixels of 255 top out at 241
            next_st.total = st.sum[SUM_W-1:SUM_SHIFT]; // [R7] [R8]
            next_st.exposure = exposure_adjust(st.exposure, st.run_max,
                                               st.sum[SUM_W-1:SUM_SHIFT]); // [R3]
            next_st.fsm = ST_ACCUM;
         end
      endcase

      // register reads, answered one cycle later
      if (reg_req.rd) begin
         next_st.rvalid = 1'b1;
         next_st.snap_ok = 1'b0;
         unique case (reg_req.addr)
            ADDR_EXPOSURE_UPPER: begin
               // freeze the low byte so the pair reads coherently
               next_st.rdata = st.exposure[15:8]; // [R1]
               next_st.lower_snap = st.exposure[7:0]; // [R2]
               next_st.snap_ok = 1'b1; // [R2]
            end
            ADDR_EXPOSURE_LOWER: begin
               next_st.rdata = st.snap_ok ? st.lower_snap : st.exposure[7:0]; // [R1] [R2]
            end
            ADDR_PEAK_PIXEL: begin
               next_st.rdata = st.peak;
            end
            ADDR_INTENSITY_TOTAL: begin
               next_st.rdata = st.total;
            end
            ADDR_LOWEST_PIXEL: begin
               next_st.rdata = st.lowest;
            end
            ADDR_CAPTURE_PORT: begin
               next_st.rdata = st.capture;
               // a read without valid data leaves the pointer alone
               if (st.ready) begin
                  ptr_next = (st.ptr == LAST_INDEX) ? 9'h000 : st.ptr + 9'h001; // [R13] [R14]
                  next_st.ptr = ptr_next;
                  next_st.ready = 1'b0; // [R15]
                  next_st.first = (ptr_next == 9'h000); // [R14] [R16]
                  next_st.coord = pixel_coord(ptr_next); // [R17]
               end
            end
            default: begin
               next_st.rdata = UNMAPPED_READ;
            end
         endcase
      end

      // any write to the capture port restarts the readout; it overrides a same-cycle load
      if (reg_req.wr && reg_req.addr == ADDR_CAPTURE_PORT) begin
         next_st.ptr = 9'h000; // [R11]
         next_st.ready = 1'b0; // [R11]
         next_st.first = 1'b1; // [R16]
         next_st.coord = pixel_coord(9'h000); // [R17]
      end
   end

   //---------------------------------------------------------------------------
   // registers
   //---------------------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= '{fsm: ST_ACCUM,
                 idx: 9'h000,
                 sum: '0,
                 run_max: 8'h00,
                 run_min: RST_RUN_MIN,
                 peak: RST_PEAK_PIXEL,
                 lowest: RST_LOWEST_PIXEL,
                 total: RST_INTENSITY_TOTAL,
                 exposure: RST_EXPOSURE,
                 lower_snap: 8'h00,
                 snap_ok: 1'b0,
                 capture: RST_CAPTURE,
                 ptr: 9'h000,
                 ready: 1'b0,
                 first: 1'b1,
                 coord: '0,
                 rdata: 8'h00,
                 rvalid: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   //---------------------------------------------------------------------------
   // outputs, all straight from flops
   //---------------------------------------------------------------------------
   assign pix_in_ready = fifo_in_ready;
   assign reg_rdata = st.rdata;
   assign reg_rvalid = st.rvalid;
   assign pixel_ready_flag = st.ready; // [R12] [R15]
   assign first_pixel_flag = st.first; // [R16]
   assign exposure_value = st.exposure; // [R1]
   assign capture_coord = st.coord;

endmodule

//--- sim/stats_checker.sv
// assertion checker for the frame statistics block
`timescale 1ns/1ps
module stats_checker
   import frame_stats_pkg::*;
#(
   parameter int unsigned BUF_DEPTH = FIFO_DEPTH
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire reg_req_t reg_req,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic pixel_ready_flag,
   input wire logic first_pixel_flag,
   input wire logic [15:0] exposure_value,
   input wire coord_t capture_coord
);
   //---------------------------------------------------------------------------
   // properties
   //---------------------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   property p_expo_upper;
      reg_req.rd && reg_req.addr == ADDR_EXPOSURE_UPPER
         |=> reg_rvalid && reg_rdata == 8'($past(exposure_value) >> 8);
   endproperty
   a_expo_upper: assert property (p_expo_upper) else $error("exposure high byte wrong");
   property p_peak_rng;
      reg_req.rd && reg_req.addr == ADDR_PEAK_PIXEL |=> reg_rdata <= PIXEL_MAX;
   endproperty
   a_peak_rng: assert property (p_peak_rng) else $error("peak out of range");
   property p_low_rng;
      reg_req.rd && reg_req.addr == ADDR_LOWEST_PIXEL |=> reg_rdata <= PIXEL_MAX;
   endproperty
   a_low_rng: assert property (p_low_rng) else $error("lowest out of range");
   property p_total_rng;
      reg_req.rd && reg_req.addr == ADDR_INTENSITY_TOTAL |=> reg_rdata <= 8'hf1;
   endproperty
   a_total_rng: assert property (p_total_rng) else $error("total out of range");
   property p_wr_restart;
      reg_req.wr && reg_req.addr == ADDR_CAPTURE_PORT
         |=> first_pixel_flag && !pixel_ready_flag && capture_coord == '0;
   endproperty
   a_wr_restart: assert property (p_wr_restart) else $error("capture restart failed");
   property p_rd_advance;
      reg_req.rd && reg_req.addr == ADDR_CAPTURE_PORT && pixel_ready_flag
         |=> !pixel_ready_flag && capture_coord != $past(capture_coord);
   endproperty
   a_rd_advance: assert property (p_rd_advance) else $error("pointer did not advance");
   property p_wrap;
      reg_req.rd && reg_req.addr == ADDR_CAPTURE_PORT && pixel_ready_flag
         && capture_coord == {5'd21, 5'd21} |=> first_pixel_flag && capture_coord == '0;
   endproperty
   a_wrap: assert property (p_wrap) else $error("pointer did not wrap");
   property p_first_pos;
      first_pixel_flag |-> capture_coord == '0;
   endproperty
   a_first_pos: assert property (p_first_pos) else $error("first flag off origin");
   property p_expo_bounds;
      $changed(exposure_value) |-> exposure_value >= EXPOSURE_MIN && exposure_value <= EXPOSURE_MAX;
   endproperty
   a_expo_bounds: assert property (p_expo_bounds) else $error("exposure out of bounds");
   // ready only drops through a capture access
   property p_ready_hold;
      pixel_ready_flag && !((reg_req.rd || reg_req.wr) && reg_req.addr == ADDR_CAPTURE_PORT)
         |=> pixel_ready_flag;
   endproperty
   a_ready_hold: assert property (p_ready_hold) else $error("ready flag dropped");
   c_capture_rd: cover property (reg_req.rd && reg_req.addr == ADDR_CAPTURE_PORT && pixel_ready_flag);
   c_capture_wr: cover property (reg_req.wr && reg_req.addr == ADDR_CAPTURE_PORT);
   c_expo_move: cover property ($changed(exposure_value));
endmodule
bind frame_stats stats_checker #(.BUF_DEPTH(BUF_DEPTH)) stats_checker_inst (
   .sys_clk(sys_clk), .arst_n(arst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
   .reg_rvalid(reg_rvalid), .pixel_ready_flag(pixel_ready_flag),
   .first_pixel_flag(first_pixel_flag), .exposure_value(exposure_value),
   .capture_coord(capture_coord));

//--- sim/pixel_source.sv
// behavioural model of the array readout feeding the pixel stream
`timescale 1ns/1ps
module pixel_source
   import frame_stats_pkg::*;
(
   input wire logic sys_clk,
   output pix_beat_t pix_in,
   output logic pix_in_valid,
   input wire logic pix_in_ready
);
   // idle lines carry junk so a stale beat is never mistaken for data
   initial begin
      pix_in = '0;
      pix_in_valid = 1'b0;
   end
   // one frame; each beat holds until ready reads high just after an edge, optional bubbles model a slow array
   task automatic send_frame(input logic [7:0] base, input logic flat, input logic gap);
      int i;
      @(posedge sys_clk);
      for (i = 0; i < PIXEL_COUNT; i++) begin
         if (gap && i[3:0] == 4'h0) begin
            pix_in_valid <= 1'b0;
            pix_in.value <= ~pix_in.value;
            @(posedge sys_clk);
         end
         pix_in.sof <= (i == 0);
         pix_in.value <= flat ? base : (i[7:0] ^ base);
         pix_in_valid <= 1'b1;
         @(posedge sys_clk);
         while (!pix_in_ready) @(posedge sys_clk);
      end
      pix_in_valid <= 1'b0;
      pix_in.value <= ~pix_in.value;
   endtask
endmodule

//--- sim/tb_top.sv
// self-checking bench for the frame statistics block
`timescale 1ns/1ps
module tb_top;
   import frame_stats_pkg::*;
   logic sys_clk;
   logic arst_n;
   pix_beat_t pix_in;
   logic pix_in_valid, pix_in_ready, reg_rvalid, pixel_ready_flag, first_pixel_flag;
   reg_req_t reg_req;
   logic [7:0] reg_rdata;
   logic [15:0] exposure_value, expo;
   coord_t capture_coord;
   int num_errors = 0;
   int cmp_count = 0;
   int cycles = 0;
   //---------------------------------------------------------------------------
   // instances
   //---------------------------------------------------------------------------
   frame_stats frame_stats_inst (.sys_clk(sys_clk), .arst_n(arst_n), .pix_in(pix_in),
      .pix_in_valid(pix_in_valid), .pix_in_ready(pix_in_ready), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .pixel_ready_flag(pixel_ready_flag),
      .first_pixel_flag(first_pixel_flag), .exposure_value(exposure_value),
      .capture_coord(capture_coord));
   pixel_source pixel_source_inst (.sys_clk(sys_clk), .pix_in(pix_in),
      .pix_in_valid(pix_in_valid), .pix_in_ready(pix_in_ready));
   //---------------------------------------------------------------------------
   // clock, watchdog and tasks
   //---------------------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // a hang costs far more than the under two thousand cycles the run needs
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
      end
   endtask
   // read: rvalid is due exactly one edge after the request
   task automatic rdck(input logic [6:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_req <= '{1'b1, 1'b0, a, 8'h00};
      @(posedge sys_clk);
      reg_req <= '0;
      #1;
      chk(16'(reg_rvalid), 16'h1, "rvalid");
      chk(16'(reg_rdata), 16'(exp), "read data");
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      reg_req <= '{1'b0, 1'b1, a, v};
      @(posedge sys_clk);
      reg_req <= '0;
      #1;
   endtask
   // send a frame, then work out its statistics and the next exposure step
   task automatic frame(input logic [7:0] base, input logic flat, input logic gap);
      int i;
      logic [7:0] v, pk, mn;
      logic [16:0] sum;
      logic [15:0] d;
      pk = 8'h00;
      mn = 8'hff;
      sum = '0;
      pixel_source_inst.send_frame(base, flat, gap);
      for (i = 0; i < PIXEL_COUNT; i++) begin
         v = flat ? base : (i[7:0] ^ base);
         sum = sum + 17'(v);
         if (v == 8'hff) v = PIXEL_MAX;
         if (v > pk) pk = v;
         if (v < mn) mn = v;
      end
      d = ((expo >> 3) == 16'h0) ? 16'h1 : (expo >> 3);
      if (pk > PEAK_HIGH || sum[16:9] > TOTAL_HIGH)
         expo = (expo - d < EXPOSURE_MIN) ? EXPOSURE_MIN : expo - d;
      else if (pk < PEAK_LOW && sum[16:9] < TOTAL_LOW)
         expo = (expo + d > EXPOSURE_MAX) ? EXPOSURE_MAX : expo + d;
      repeat (20) @(posedge sys_clk);
      rdck(ADDR_PEAK_PIXEL, pk);
      rdck(ADDR_LOWEST_PIXEL, mn);
      rdck(ADDR_INTENSITY_TOTAL, sum[16:9]);
      rdck(ADDR_EXPOSURE_UPPER, expo[15:8]);
      rdck(ADDR_EXPOSURE_LOWER, expo[7:0]);
      chk(exposure_value, expo, "live exposure");
      // the buffer drains every frame, so the stream must be open again
      chk(16'(pix_in_ready), 16'h1, "stream ready");
   endtask
   //---------------------------------------------------------------------------
   // main sequence
   //---------------------------------------------------------------------------
   initial begin
      arst_n = 1'b0;
      reg_req = '0;
      expo = RST_EXPOSURE;
      repeat (5) @(posedge sys_clk);
      arst_n <= 1'b1;
      rdck(ADDR_EXPOSURE_UPPER, 8'h00);
      chk(16'(pix_in_ready), 16'h1, "ready after reset");
      rdck(ADDR_EXPOSURE_LOWER, 8'h64);
      rdck(ADDR_PEAK_PIXEL, RST_PEAK_PIXEL);
      rdck(ADDR_INTENSITY_TOTAL, RST_INTENSITY_TOTAL);
      rdck(ADDR_LOWEST_PIXEL, RST_LOWEST_PIXEL);
      wr(ADDR_PEAK_PIXEL, 8'h11);
      rdck(ADDR_PEAK_PIXEL, RST_PEAK_PIXEL);
      rdck(7'h20, UNMAPPED_READ);
      wr(ADDR_CAPTURE_PORT, 8'h5a);
      chk(16'(first_pixel_flag), 16'h1, "first after write");
      chk(16'(pixel_ready_flag), 16'h0, "ready after write");
      // full ramp hits 255, so the peak must clamp
      frame(8'h00, 1'b0, 1'b0);
      chk(16'(pixel_ready_flag), 16'h1, "ready after frame");
      rdck(ADDR_CAPTURE_PORT, 8'h00);
      chk(16'(pixel_ready_flag), 16'h0, "ready after read");
      chk(16'(first_pixel_flag), 16'h0, "first after read");
      chk(16'(capture_coord), 16'({5'd0, 5'd1}), "coord");
      // flat 255 frame drives the total to its ceiling
      frame(8'hff, 1'b1, 1'b1);
      rdck(ADDR_INTENSITY_TOTAL, 8'hf1);
      // host side average from the total; a flat 255 frame comes out at 254
      chk(16'((32'(reg_rdata) * 32'd512) / 32'd484), 16'h00fe, "average");
      rdck(ADDR_CAPTURE_PORT, 8'hff);
      chk(16'(capture_coord), 16'({5'd0, 5'd2}), "coord");
      frame(8'h35, 1'b0, 1'b1);
      rdck(ADDR_CAPTURE_PORT, 8'h37);
      // a read with no fresh byte returns the stale one and must not advance
      rdck(ADDR_CAPTURE_PORT, 8'h37);
      chk(16'(capture_coord), 16'h0003, "coord held");
      chk(16'(pixel_ready_flag), 16'h0, "ready stays low");
      give_verdict();
   end
endmodule
